// file: hdl/i2c_frame_pkg.sv
// How it works
// - Bit-count 000 gives 8 data bits, 001-111 give 1-7; ack adds a clock
// - A start condition clears the bit-count field; otherwise it holds
// - Master transmitter releases the data line in the ack clock
// - Master or addressed slave receiver in ack mode drives the data line low in the ack clock
// - Slave acks its own address or a general call
// - Addressed slave transmitter releases the data line in each ack clock
// - Without ack mode no ack clock is made, counted or answered
// - Clock-period field sets high/low counts 9/12 up to 263/266 cycles
// - Master holds start and sets up stop for one high period
// - Slave keeps the clock low for one low period after service-done
// - A clock pulled low during our high count ends it, driving low
// - High count starts only once the bus clock is seen high
// - Master pulls the clock low when its high count completes
// - Role-select 1 makes a master, 0 a slave
// - Stop condition or lost arbitration clears role-select to slave
// - Each finished word raises a one-cycle request, except foreign traffic to an unaddressed slave
// - Clock held low while service-done flag is 0 after a request
// - Direction bit 1 means transmitter, 0 receiver
package i2c_frame_pkg;

    localparam logic [2:0] REG_CTRL1 = 3'h0;
    localparam logic [2:0] REG_CTRL2 = 3'h1;
    localparam logic [2:0] REG_DATA = 3'h2;
    localparam logic [2:0] REG_OWN_ADDR = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;

    localparam int CTRL1_BC_LSB = 5;
    localparam int CTRL1_ACK_BIT = 4;
    localparam int CTRL1_SCK_LSB = 0;
    localparam int CTRL2_MST_BIT = 7;
    localparam int CTRL2_TRX_BIT = 6;
    localparam int CTRL2_BB_BIT = 5;
    localparam int CTRL2_PIN_BIT = 4;
    localparam int OWN_ADDR_LSB = 1;

    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [6:0] OWN_ADDR_RST = 7'h00;
    localparam logic [6:0] GENERAL_CALL = 7'h00;

    // Table rows follow high = 7 + 2^(sck+1), low = high + 3
    localparam logic [8:0] HIGH_BASE = 9'h007;
    localparam logic [8:0] LOW_EXTRA = 9'h003;

    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_LOW, ST_WAIT_HIGH, ST_HIGH,
        ST_STOP_LOW, ST_STOP_WAIT, ST_STOP_HIGH
    } clk_state_t;

    function automatic logic [3:0] data_bits(input logic [2:0] bc);
        return (bc == 3'h0) ? 4'h8 : {1'b0, bc};
    endfunction : data_bits

    function automatic logic [3:0] word_clocks(input logic [2:0] bc,
                                              input logic ack);
        return data_bits(bc) + {3'h0, ack};
    endfunction : word_clocks

    function automatic logic [8:0] high_cycles(input logic [2:0] sck);
        return HIGH_BASE + (9'h002 << sck);
    endfunction : high_cycles

    function automatic logic [8:0] low_cycles(input logic [2:0] sck);
        return high_cycles(sck) + LOW_EXTRA;
    endfunction : low_cycles

endpackage : i2c_frame_pkg

// file: hdl/i2c_bit_framing_and_clocking.sv
`timescale 1ns/1ps
module i2c_bit_framing_and_clocking
    import i2c_frame_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_clock_line_pin_in,
    output logic o_clock_line_pin_out,
    output logic o_clock_line_pin_oe,
    input wire logic i_data_line_pin_in,
    output logic o_data_line_pin_out,
    output logic o_data_line_pin_oe,
    output logic o_word_done
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and bus event detection

logic scl_m_r, scl_s_r, scl_d_r;
logic sda_m_r, sda_s_r, sda_d_r;

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
    begin
        scl_m_r <= 1'b1;
        scl_s_r <= 1'b1;
        scl_d_r <= 1'b1;
        sda_m_r <= 1'b1;
        sda_s_r <= 1'b1;
        sda_d_r <= 1'b1;
    end
    else
    begin
        scl_m_r <= i_clock_line_pin_in;
        scl_s_r <= scl_m_r;
        scl_d_r <= scl_s_r;
        sda_m_r <= i_data_line_pin_in;
        sda_s_r <= sda_m_r;
        sda_d_r <= sda_s_r;
    end
end

logic scl_rise, scl_fall, start_det, stop_det;
assign scl_rise = scl_s_r & ~scl_d_r;
assign scl_fall = ~scl_s_r & scl_d_r;
assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
assign stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

////////////////////////////////////////////////////////////////////////////////
// Register strobes and shared decode

logic wr_ctrl1, wr_ctrl2, wr_data, wr_addr, rd_data;
assign wr_ctrl1 = i_wr && (i_addr == REG_CTRL1);
assign wr_ctrl2 = i_wr && (i_addr == REG_CTRL2);
assign wr_data = i_wr && (i_addr == REG_DATA);
assign wr_addr = i_wr && (i_addr == REG_OWN_ADDR);
assign rd_data = i_rd && (i_addr == REG_DATA);

logic [2:0] bc_r, sck_r;
logic ack_en_r, mst_r, trx_r, pin_r, bus_busy_r;
logic al_r, aas_r, gcall_r, lrb_r, addr_phase_r;
logic [6:0] own_addr_r;
logic [7:0] tx_r, rx_r;
logic [3:0] bitn_r;
logic sda_drv_r, slv_hold_r, start_pend_r, stop_pend_r;
logic [8:0] cnt_r;
clk_state_t state_r, state_nxt;

logic [3:0] nbits, nclk;
logic [8:0] t_high, t_low;
assign nbits = data_bits(bc_r);
assign nclk = word_clocks(bc_r, ack_en_r);
assign t_high = high_cycles(sck_r);
assign t_low = low_cycles(sck_r);

logic in_word, addr_match, word_end, al_hit;
assign in_word = mst_r || aas_r || addr_phase_r;
assign addr_match = (rx_r[7:1] == own_addr_r) || (rx_r[7:1] == GENERAL_CALL);
// Unaddressed slaves stay silent: no request for foreign traffic
assign word_end = scl_fall && in_word && (bitn_r == nclk)
    && (mst_r || aas_r || addr_match);
assign al_hit = scl_rise && mst_r && trx_r && (bitn_r < nbits)
    && !sda_drv_r && !sda_s_r;

////////////////////////////////////////////////////////////////////////////////
// Control registers

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
    begin
        bc_r <= CTRL1_RST[CTRL1_BC_LSB +: 3];
        ack_en_r <= CTRL1_RST[CTRL1_ACK_BIT];
        sck_r <= CTRL1_RST[CTRL1_SCK_LSB +: 3];
    end
    else if (start_det)
        bc_r <= 3'h0;
    else if (wr_ctrl1)
    begin
        bc_r <= i_wdata[CTRL1_BC_LSB +: 3];
        ack_en_r <= i_wdata[CTRL1_ACK_BIT];
        sck_r <= i_wdata[CTRL1_SCK_LSB +: 3];
    end
end

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
        own_addr_r <= OWN_ADDR_RST;
    else if (wr_addr)
        own_addr_r <= i_wdata[OWN_ADDR_LSB +: 7];
end

// Role and direction: hardware events take priority over software writes
always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
    begin
        mst_r <= 1'b0;
        trx_r <= 1'b0;
    end
    else if (stop_det || al_hit)
    begin
        mst_r <= 1'b0;
        trx_r <= 1'b0;
    end
    else if (word_end && addr_phase_r && !mst_r)
        trx_r <= rx_r[0];
    else if (word_end && addr_phase_r && !lrb_r)
        trx_r <= ~tx_r[0];
    else if (wr_ctrl2)
    begin
        mst_r <= i_wdata[CTRL2_MST_BIT];
        trx_r <= i_wdata[CTRL2_TRX_BIT];
    end
end

// The word-end clear beats a same-cycle software set so no request is lost
always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
        pin_r <= 1'b1;
    else if (word_end)
        pin_r <= 1'b0;
    else if (wr_data || (wr_ctrl2 && i_wdata[CTRL2_PIN_BIT]))
        pin_r <= 1'b1;
end

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
    begin
        start_pend_r <= 1'b0;
        stop_pend_r <= 1'b0;
    end
    else
    begin
        if (state_r == ST_START)
            start_pend_r <= 1'b0;
        else if (wr_ctrl2 && i_wdata[CTRL2_MST_BIT]
                 && i_wdata[CTRL2_BB_BIT] && !bus_busy_r)
            start_pend_r <= 1'b1;
        if (state_r == ST_STOP_LOW || !mst_r)
            stop_pend_r <= 1'b0;
        else if (wr_ctrl2 && i_wdata[CTRL2_MST_BIT]
                 && !i_wdata[CTRL2_BB_BIT] && bus_busy_r)
            stop_pend_r <= 1'b1;
    end
end

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
        al_r <= 1'b0;
    else if (al_hit)
        al_r <= 1'b1;
    else if (wr_data || rd_data || wr_ctrl2)
        al_r <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Word framing on observed bus clock edges

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
    begin
        bus_busy_r <= 1'b0;
        addr_phase_r <= 1'b0;
        aas_r <= 1'b0;
        gcall_r <= 1'b0;
        bitn_r <= 4'h0;
        rx_r <= 8'h00;
        lrb_r <= 1'b0;
    end
    else if (start_det)
    begin
        bus_busy_r <= 1'b1;
        addr_phase_r <= 1'b1;
        aas_r <= 1'b0;
        gcall_r <= 1'b0;
        bitn_r <= 4'h0;
    end
    else if (stop_det)
    begin
        bus_busy_r <= 1'b0;
        addr_phase_r <= 1'b0;
        aas_r <= 1'b0;
        bitn_r <= 4'h0;
    end
    else if (scl_rise && in_word && bitn_r < nclk)
    begin
        bitn_r <= bitn_r + 4'h1;
        if (bitn_r < nbits)
            rx_r <= {rx_r[6:0], sda_s_r};
        else
            lrb_r <= sda_s_r;
    end
    else if (scl_fall && in_word && bitn_r == nclk)
    begin
        bitn_r <= 4'h0;
        addr_phase_r <= 1'b0;
        if (addr_phase_r && !mst_r && addr_match)
        begin
            aas_r <= 1'b1;
            gcall_r <= (rx_r[7:1] == GENERAL_CALL);
        end
    end
end

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
        tx_r <= 8'h00;
    else if (wr_data)
        tx_r <= i_wdata;
end

// High means pulling the data line low; it changes while the clock is low, except at start, stop and lost arbitration
always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
        sda_drv_r <= 1'b0;
    else if (al_hit || stop_det)
        sda_drv_r <= 1'b0;
    else if (state_r == ST_STOP_HIGH && cnt_r >= t_high - 9'h001)
        sda_drv_r <= 1'b0;
    else if (state_r == ST_IDLE && start_pend_r)
        sda_drv_r <= 1'b1;
    else if (state_r == ST_LOW && stop_pend_r)
        sda_drv_r <= 1'b1;
    else if (wr_data && in_word)
        sda_drv_r <= trx_r & ~i_wdata[7];
    else if (scl_fall && in_word)
    begin
        if (bitn_r == nclk)
            sda_drv_r <= 1'b0;
        else if (bitn_r < nbits)
            sda_drv_r <= trx_r & ~tx_r[3'(3'h7 - bitn_r[2:0])];
        else if (addr_phase_r && !mst_r)
            sda_drv_r <= addr_match;
        else
            sda_drv_r <= ~trx_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Serial clock generation, synchronisation and stretching

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
        cnt_r <= 9'h000;
    else if (scl_rise || scl_fall || wr_data || state_nxt != state_r)
        cnt_r <= 9'h000;
    else if (cnt_r != 9'h1ff)
        cnt_r <= cnt_r + 9'h001;
end

always_comb
begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE:
            if (start_pend_r && mst_r)
                state_nxt = ST_START;
        ST_START:
            if (cnt_r >= t_high - 9'h001)
                state_nxt = ST_LOW;
        ST_LOW:
            if (!mst_r)
                state_nxt = ST_IDLE;
            else if (stop_pend_r)
                state_nxt = ST_STOP_LOW;
            else if (pin_r && cnt_r >= t_low - 9'h001)
                state_nxt = ST_WAIT_HIGH;
        ST_WAIT_HIGH:
            if (!mst_r)
                state_nxt = ST_IDLE;
            else if (scl_s_r)
                state_nxt = ST_HIGH;
        ST_HIGH:
            if (!mst_r)
                state_nxt = ST_IDLE;
            else if (scl_fall)
                state_nxt = ST_LOW;
            else if (cnt_r >= t_high - 9'h001)
                state_nxt = ST_LOW;
        ST_STOP_LOW:
            if (cnt_r >= t_low - 9'h001)
                state_nxt = ST_STOP_WAIT;
        ST_STOP_WAIT:
            if (scl_s_r)
                state_nxt = ST_STOP_HIGH;
        ST_STOP_HIGH:
            if (cnt_r >= t_high - 9'h001)
                state_nxt = ST_IDLE;
        default:
            state_nxt = ST_IDLE;
    endcase
end

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
        state_r <= ST_IDLE;
    else
        state_r <= state_nxt;
end

// Slave stretch: held from word end until one low period after service
always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
        slv_hold_r <= 1'b0;
    else if (word_end && !mst_r)
        slv_hold_r <= 1'b1;
    else if (stop_det || (pin_r && cnt_r >= t_low - 9'h001))
        slv_hold_r <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Pin drivers, request pulse and read port

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
    begin
        o_clock_line_pin_oe <= 1'b0;
        o_data_line_pin_oe <= 1'b0;
        o_word_done <= 1'b0;
    end
    else
    begin
        o_clock_line_pin_oe <= state_nxt == ST_LOW
            || state_nxt == ST_STOP_LOW || slv_hold_r;
        o_data_line_pin_oe <= sda_drv_r;
        o_word_done <= word_end;
    end
end

// Open-drain lines only ever pull low
assign o_clock_line_pin_out = 1'b0;
assign o_data_line_pin_out = 1'b0;

logic [7:0] status;
assign status = {mst_r, trx_r, bus_busy_r, pin_r,
                 al_r, aas_r, gcall_r, lrb_r};

always_ff @(posedge i_sys_clk)
begin
    if (i_rst)
        o_rdata <= 8'h00;
    else if (i_rd)
    begin
        case (i_addr)
            REG_CTRL1: o_rdata <= {bc_r, ack_en_r, 1'b0, sck_r};
            REG_CTRL2: o_rdata <= status;
            REG_DATA: o_rdata <= rx_r;
            REG_OWN_ADDR: o_rdata <= {own_addr_r, 1'b0};
            REG_STATUS: o_rdata <= status;
            default: o_rdata <= 8'h00;
        endcase
    end
    else
        o_rdata <= 8'h00;
end

endmodule : i2c_bit_framing_and_clocking

// file: testbench/i2c_frame_sva.sv
`timescale 1ns/1ps
module i2c_frame_sva (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_addr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_clock_line_pin_in,
    input wire logic o_clock_line_pin_out,
    input wire logic o_clock_line_pin_oe,
    input wire logic o_data_line_pin_out,
    input wire logic o_data_line_pin_oe,
    input wire logic o_word_done
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    int hi_run;
    int oe_run;
    // Raw line high run and own pull run, both from the shortest setting
    always_ff @(posedge i_sys_clk)
    begin
        hi_run <= i_clock_line_pin_in ? hi_run + 1 : 0;
        oe_run <= o_clock_line_pin_oe ? oe_run + 1 : 0;
    end
    ////////////////////////////////////////////////////////////
    chk_open_drain: assert property (
        !o_clock_line_pin_out && !o_data_line_pin_out)
        else $error("pin output drives high");
    chk_done_pulse: assert property (
        o_word_done |=> !o_word_done)
        else $error("word pulse longer than one cycle");
    chk_hold_after_word: assert property (
        o_word_done |-> o_clock_line_pin_oe ##1 o_clock_line_pin_oe)
        else $error("clock not held after word");
    chk_high_full_count: assert property (
        $rose(o_clock_line_pin_oe) && i_clock_line_pin_in |-> hi_run >= 9)
        else $error("clock pulled before high count");
    chk_low_full_count: assert property (
        $fell(o_clock_line_pin_oe) |-> oe_run >= 12)
        else $error("clock released before low count");
    chk_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_unmapped_zero: assert property (
        $past(i_rd) && $past(i_addr) > 3'h4 |-> o_rdata == 8'h00)
        else $error("unmapped index read nonzero");
    chk_reset_quiet: assert property (
        $fell(i_rst) |-> !o_clock_line_pin_oe && !o_data_line_pin_oe)
        else $error("pins pulled after reset");
    cov_word: cover property (o_word_done);
    cov_release: cover property ($fell(o_clock_line_pin_oe));
    cov_data_pull: cover property ($rose(o_data_line_pin_oe));
endmodule : i2c_frame_sva
bind i2c_bit_framing_and_clocking i2c_frame_sva u_chk (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_clock_line_pin_in(i_clock_line_pin_in),
    .o_clock_line_pin_out(o_clock_line_pin_out),
    .o_clock_line_pin_oe(o_clock_line_pin_oe),
    .o_data_line_pin_out(o_data_line_pin_out),
    .o_data_line_pin_oe(o_data_line_pin_oe), .o_word_done(o_word_done)
);

// file: testbench/far_target.sv
`timescale 1ns/1ps
module far_target (
    input wire logic i_sys_clk,
    input wire logic i_clr,
    input wire logic i_scl,
    input wire logic [7:0] i_ack_at,
    input wire logic [7:0] i_stretch,
    output logic o_scl_oe,
    output logic o_sda_oe
);
    logic prev_r;
    logic [7:0] falls_r;
    logic [7:0] hold_r;
    // Acks from the chosen clock fall to the next; 0 turns acking off
    always_ff @(posedge i_sys_clk)
    begin
        prev_r <= i_scl;
        if (i_clr)
            falls_r <= 8'h00;
        else if (prev_r && !i_scl)
            falls_r <= falls_r + 8'h01;
        o_sda_oe <= (i_ack_at != 8'h00) && (falls_r == i_ack_at);
    end
    // Stretches each low phase well beyond the 12-cycle minimum
    always_ff @(posedge i_sys_clk)
    begin
        if (prev_r && !i_scl)
            hold_r <= i_stretch;
        else if (hold_r != 8'h00)
            hold_r <= hold_r - 8'h01;
    end
    assign o_scl_oe = (hold_r != 8'h00);
endmodule : far_target

// file: testbench/i2c_bit_framing_and_clocking_tb.sv
`timescale 1ns/1ps
module i2c_bit_framing_and_clocking_tb
    import i2c_frame_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic c_oe, c_out, d_oe, d_out, o_word_done, t_scl, t_sda, scl, sda;
    logic t_clr = 1'b1;
    logic [7:0] t_ack_at = 8'h00;
    logic [7:0] t_stretch = 8'h00;
    logic [31:0] seed = 32'h00013e10;
    int n_mismatch, cmp_count, nclk, run, hi_min, hi_max, lo_min;
    bit armed;
    logic [1:0] bits[$];
    // Both lines have pull-ups
    assign scl = !(c_oe || t_scl);
    assign sda = !(d_oe || t_sda);
    always #50 i_sys_clk = ~i_sys_clk;
    i2c_bit_framing_and_clocking DUT (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_clock_line_pin_in(scl), .o_clock_line_pin_out(c_out),
        .o_clock_line_pin_oe(c_oe), .i_data_line_pin_in(sda),
        .o_data_line_pin_out(d_out), .o_data_line_pin_oe(d_oe),
        .o_word_done(o_word_done)
    );
    far_target u_far (
        .i_sys_clk(i_sys_clk), .i_clr(t_clr), .i_scl(scl),
        .i_ack_at(t_ack_at), .i_stretch(t_stretch),
        .o_scl_oe(t_scl), .o_sda_oe(t_sda)
    );
    ////////////////////////////////////////////////////////////
    // Line monitor: clocks per word, {data line, own pull} per bit
    logic last_scl = 1'b1;
    // A low run is only complete at the rise that ends it
    always @(posedge i_sys_clk)
    begin
        if (armed && scl && run < lo_min && scl_changed(scl))
            lo_min = run;
        if (armed && !scl && run > 0 && scl_changed(scl))
        begin
            hi_min = (run < hi_min) ? run : hi_min;
            hi_max = (run > hi_max) ? run : hi_max;
        end
        if (scl_changed(scl) && scl)
        begin
            nclk++;
            bits.push_back({sda, d_oe});
            armed = 1;
        end
        run = scl_changed(scl) ? 1 : run + 1;
        last_scl = scl;
    end
    function automatic bit scl_changed(input logic v);
        return v !== last_scl;
    endfunction : scl_changed
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        d = o_rdata;
    endtask : rd
    task automatic clear_mon(input logic [7:0] ack_at, input logic [7:0] st);
        @(negedge i_sys_clk);
        nclk = 0;
        armed = 0;
        hi_min = 9999;
        hi_max = 0;
        lo_min = 9999;
        bits.delete();
        t_ack_at = ack_at;
        t_stretch = st;
        t_clr = 1'b1;
        @(negedge i_sys_clk);
        t_clr = 1'b0;
    endtask : clear_mon
    task automatic wait_word(input int th, input int lo);
        int k;
        for (k = 0; k < 20000 && o_word_done !== 1'b1; k++)
            @(negedge i_sys_clk);
        check(k < 20000, 1);
        check(hi_min >= th && hi_max <= th + 6, 1);
        check(lo_min >= lo, 1);
    endtask : wait_word
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    initial
    begin
        #1000000;
        n_mismatch++;
        summarize();
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] r;
        logic [7:0] a;
        int th_tab[3] = '{9, 11, 15};
        int sck, th, bc, i;
        repeat (6) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rd(REG_CTRL1, r);
        check(r, 8'h00);
        rd(REG_STATUS, r);
        check(r, 8'h10);
        a = 8'(xs());
        wr(3'h6, a);
        rd(3'h6, r);
        check(r, 8'h00);
        wr(REG_OWN_ADDR, a);
        rd(REG_OWN_ADDR, r);
        check(r, {a[7:1], 1'b0});
        $display("registers done");
        // Address word: partner acks, we must let go of data in ack clock
        sck = xs() % 3;
        th = th_tab[sck];
        bc = xs() % 7 + 1;
        a = {7'(xs() >> 9), 1'b1};
        wr(REG_CTRL1, {bc[2:0], 1'b1, 1'b0, sck[2:0]});
        wr(REG_DATA, a);
        clear_mon(8'h09, 8'h00);
        wr(REG_CTRL2, 8'hf0);
        wait_word(th, th + 3);
        check(nclk, 9);
        for (i = 0; i < 8; i++)
            check(bits[i], {a[7 - i], ~a[7 - i]});
        check(bits[8], 2'b00);
        rd(REG_CTRL1, r);
        check(r, {3'h0, 1'b1, 1'b0, sck[2:0]});
        rd(REG_STATUS, r);
        check(r, 8'ha0);
        $display("address word done");
        // Receive word under a stretching partner
        bc = xs() % 7 + 1;
        wr(REG_CTRL1, {bc[2:0], 1'b1, 1'b0, sck[2:0]});
        clear_mon(8'h00, 8'h28);
        wr(REG_DATA, 8'h00);
        wait_word(th, 40);
        check(nclk, bc + 1);
        for (i = 0; i < bc; i++)
            check(bits[i], 2'b10);
        check(bits[bc], 2'b01);
        rd(REG_DATA, r);
        check(r & ((8'h01 << bc) - 8'h01), (8'h01 << bc) - 8'h01);
        $display("receive word done");
        // No-ack word: no extra clock, no pull on data
        bc = xs() % 7 + 1;
        wr(REG_CTRL1, {bc[2:0], 1'b0, 1'b0, sck[2:0]});
        clear_mon(8'h00, 8'h00);
        wr(REG_DATA, 8'h00);
        wait_word(th, th + 3);
        check(nclk, bc);
        for (i = 0; i < bc; i++)
            check(bits[i], 2'b10);
        $display("no-ack word done");
        // Stop hands the role back to slave
        wr(REG_CTRL2, 8'hd0);
        r = 8'hff;
        for (i = 0; i < 200 && r[7] !== 1'b0; i++)
            rd(REG_STATUS, r);
        check(r[7:5], 3'b000);
        check({scl, sda}, 2'b11);
        $display("stop done");
        summarize();
    end
endmodule : i2c_bit_framing_and_clocking_tb
